// [bench/sabx_prog_mem.sv]
// program memory model on the far side of the fetch port
// assumes combinational read in the cycle that mem_rd is high
`timescale 1ns/100ps
`default_nettype none
module sabx_prog_mem (
  input  wire logic        clk_in,
  input  wire logic [15:0] addr_in,
  input  wire logic        rd_in,
  output logic      [7:0]  rdata_out
);
  logic [7:0] mem [0:65535];
  logic [7:0] last_q = 8'ha5;
  // a released bus shows the inverse of the last byte, so stale sampling is caught
  assign rdata_out = rd_in ? mem[addr_in] : ~last_q;
  always @(posedge clk_in) begin
    if (rd_in) begin
      last_q <= mem[addr_in];
    end
  end
endmodule
`default_nettype wire

// [bench/tb.sv]
// self-checking bench for the execution block
// assumes the program memory model and register access over avalon-mm
`timescale 1ns/100ps
`default_nettype none
`include "sabx_consts.svh"
module tb;
  import sabx_pkg::*;
  logic        clk_in;
  logic        rst_n_in;
  logic [4:0]  adr;
  logic        rd;
  logic        wr;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic        wreq;
  logic [15:0] maddr;
  logic        mrd;
  logic [7:0]  mdat;
  logic        irq;
  logic [31:0] r;
  logic [7:0]  op;
  logic [7:0]  rel;
  logic        tk;
  logic [7:0]  fl [10] = '{8'h60, 8'hff, 8'he0, 8'h64, 8'h62, 8'h61, 8'h70, 8'h68, 8'he4, 8'h66};
  int          errors = 0;
  int          checked = 0;
  int          cycles = 0;

  sabx_exec u_sabx_exec (.clk_in(clk_in), .rst_n_in(rst_n_in), .avs_address_in(adr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdat), .avs_byteenable_in(4'hf),
    .avs_readdata_out(rdat), .avs_waitrequest_out(wreq), .mem_addr_out(maddr),
    .mem_rd_out(mrd), .mem_rdata_in(mdat), .irq_pin_in(irq));
  sabx_prog_mem u_sabx_prog_mem (.clk_in(clk_in), .addr_in(maddr), .rd_in(mrd),
    .rdata_out(mdat));

  task automatic close_out();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // the request is held until the rising edge at which waitrequest is sampled low
  task automatic av_wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_in);
    adr <= a;
    wdat <= d;
    wr <= 1'b1;
    do @(posedge clk_in); while (wreq !== 1'b0);
    wr <= 1'b0;
  endtask

  task automatic av_rd(input logic [4:0] a, output logic [31:0] d);
    @(posedge clk_in);
    adr <= a;
    rd <= 1'b1;
    do @(posedge clk_in); while (wreq !== 1'b0);
    d = rdat;
    rd <= 1'b0;
  endtask

  task automatic run_op(input logic [15:0] pc, input logic [7:0] o, input logic [7:0] opnd);
    logic [31:0] s;
    u_sabx_prog_mem.mem[pc] = o;
    u_sabx_prog_mem.mem[pc + 16'h1] = opnd;
    av_wr(`SABX_REG_PC, {16'h0, pc});
    av_wr(`SABX_REG_CTRL, 32'h2);
    s = 32'h2;
    while (s[1]) av_rd(`SABX_REG_CTRL, s);
    s = 32'h1;
    while (s[0]) av_rd(`SABX_REG_STATUS, s);
  endtask

  task automatic adj(input logic [7:0] o, input logic [4:0] ra, input logic [15:0] st,
                     input logic [7:0] imm, input logic [15:0] ex);
    logic [31:0] s;
    av_wr(ra, {16'h0, st});
    run_op(16'h0200, o, imm);
    av_rd(ra, s);
    check("adjusted reg", s[15:0], ex);
    av_rd(`SABX_REG_FLAGS, s);
    check("adjust flags", {8'h0, s[7:0]}, 16'h00f7);
    av_rd(`SABX_REG_STATUS, s);
    check("adjust cycles", {12'h0, s[11:8]}, 16'h0002);
  endtask

  function automatic logic taken(input logic [7:0] o, input logic [7:0] f, input logic p);
    logic nv;
    nv = f[`SABX_FLAG_N] ^ f[`SABX_FLAG_V];
    case (o)
      8'h20: taken = 1'b1;
      8'h21: taken = 1'b0;
      8'h22: taken = ~(f[`SABX_FLAG_C] | f[`SABX_FLAG_Z]);
      8'h23: taken = f[`SABX_FLAG_C] | f[`SABX_FLAG_Z];
      8'h24: taken = ~f[`SABX_FLAG_C];
      8'h25: taken = f[`SABX_FLAG_C];
      8'h26: taken = ~f[`SABX_FLAG_Z];
      8'h27: taken = f[`SABX_FLAG_Z];
      8'h28: taken = ~f[`SABX_FLAG_H];
      8'h29: taken = f[`SABX_FLAG_H];
      8'h2a: taken = ~f[`SABX_FLAG_N];
      8'h2b: taken = f[`SABX_FLAG_N];
      8'h2c: taken = ~f[`SABX_FLAG_I];
      8'h2d: taken = f[`SABX_FLAG_I];
      8'h2e: taken = ~p;
      8'h2f: taken = p;
      8'h90: taken = ~nv;
      8'h91: taken = nv;
      8'h92: taken = ~(f[`SABX_FLAG_Z] | nv);
      default: taken = f[`SABX_FLAG_Z] | nv;
    endcase
  endfunction

  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end

  // hang guard: the full run needs well under half of this
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      errors++;
      close_out();
    end
  end

  initial begin
    rst_n_in = 1'b0;
    adr = 5'h00;
    rd = 1'b0;
    wr = 1'b0;
    wdat = 32'h0;
    irq = 1'b0;
    repeat (3) @(posedge clk_in);
    rst_n_in <= 1'b1;
    av_rd(`SABX_REG_SP, r);
    check("sp reset", r[15:0], 16'h00ff);
    av_rd(`SABX_REG_HX, r);
    check("hx reset", r[15:0], 16'h0000);
    av_rd(`SABX_REG_FLAGS, r);
    check("flags reset", {8'h0, r[7:0]}, 16'h0068);
    av_rd(5'h1c, r);
    check("unmapped", r[15:0], 16'h0000);
    $display("test reset done");
    av_wr(`SABX_REG_FLAGS, 32'hd7);
    adj(8'ha7, `SABX_REG_SP, 16'h0010, 8'hf0, 16'h0000);
    adj(8'ha7, `SABX_REG_SP, 16'h0100, 8'h80, 16'h0080);
    adj(8'haf, `SABX_REG_HX, 16'h01ff, 8'h01, 16'h0200);
    adj(8'haf, `SABX_REG_HX, 16'h0200, 8'hff, 16'h01ff);
    adj(8'haf, `SABX_REG_HX, 16'h0100, 8'h80, 16'h0080);
    adj(8'haf, `SABX_REG_HX, 16'h0000, 8'h7f, 16'h007f);
    $display("test adjust done");
    for (int k = 0; k < 2; k++) begin
      av_wr(`SABX_REG_FLAGS, 32'h61);
      av_wr(`SABX_REG_HX, k ? 32'h0180 : 32'h0100);
      run_op(16'h0300, 8'h5a, 8'h00);
      av_rd(`SABX_REG_HX, r);
      check("low dec hx", r[15:0], k ? 16'h017f : 16'h01ff);
      av_rd(`SABX_REG_FLAGS, r);
      check("low dec flags", {8'h0, r[7:0]}, k ? 16'h00e1 : 16'h0065);
    end
    $display("test low decrement done");
    for (int fi = 0; fi < 10; fi++) begin
      irq <= fi[0];
      av_wr(`SABX_REG_FLAGS, {24'h0, fl[fi]});
      rel = fi[1] ? 8'h80 : 8'h7f;
      for (int i = 0; i < 20; i++) begin
        op = (i < 16) ? 8'h20 + 8'(i) : 8'h80 + 8'(i);
        run_op(16'h4000, op, rel);
        tk = taken(op, fl[fi], fi[0]);
        av_rd(`SABX_REG_PC, r);
        check("branch pc", r[15:0], 16'h4002 + (tk ? {{8{rel[7]}}, rel} : 16'h0));
        av_rd(`SABX_REG_STATUS, r);
        check("branch status", {8'h0, r[11:8], 3'h0, r[1]}, {8'h0, 4'h3, 3'h0, tk});
        av_rd(`SABX_REG_FLAGS, r);
        check("branch flags", {8'h0, r[7:0]}, {8'h0, fl[fi]});
      end
    end
    $display("test branches done");
    close_out();
  end
endmodule
`default_nettype wire

// [verilog/sabx_adder.sv]
// 16-bit base plus sign-extended 8-bit displacement
// assumes a purely combinational use on the processor clock
`timescale 1ns/100ps
`default_nettype none
module sabx_adder
  import sabx_pkg::*;
(
  input  wire sabx_word_t base_in,
  input  wire sabx_byte_t offset_in,
  output logic [15:0]     sum_out
);
  wire sabx_word_t ext_off;

  assign ext_off = {{8{offset_in[7]}}, offset_in};
  assign sum_out = base_in + ext_off;
endmodule
`default_nettype wire

// [verilog/sabx_cond.sv]
// branch decode and condition evaluation
// assumes flags and a synchronised interrupt pin level on the same clock
`timescale 1ns/100ps
`default_nettype none
`include "sabx_consts.svh"
module sabx_cond
  import sabx_pkg::*;
(
  input  wire sabx_byte_t opcode_in,
  input  wire sabx_byte_t flags_in,
  input  wire logic       irq_level_in,
  output logic            is_branch_out,
  output logic            taken_out
);
  wire c;
  wire z;
  wire n;
  wire v;
  wire h;
  wire i;
  wire nv;

  assign c  = flags_in[`SABX_FLAG_C];
  assign z  = flags_in[`SABX_FLAG_Z];
  assign n  = flags_in[`SABX_FLAG_N];
  assign v  = flags_in[`SABX_FLAG_V];
  assign h  = flags_in[`SABX_FLAG_H];
  assign i  = flags_in[`SABX_FLAG_I];
  assign nv = n ^ v;

  always_comb begin
    is_branch_out = 1'b1;
    taken_out     = 1'b0;
    unique case (opcode_in)
      `SABX_OP_BGE:  taken_out = ~nv;
      `SABX_OP_BLT:  taken_out = nv;
      `SABX_OP_BGT:  taken_out = ~(z | nv);
      `SABX_OP_BLE:  taken_out = z | nv;
      `SABX_OP_BHI:  taken_out = ~(c | z);
      `SABX_OP_BLS:  taken_out = c | z;
      `SABX_OP_BCS:  taken_out = c;
      `SABX_OP_BCC:  taken_out = ~c;
      `SABX_OP_BEQ:  taken_out = z;
      `SABX_OP_BNE:  taken_out = ~z;
      `SABX_OP_BMI:  taken_out = n;
      `SABX_OP_BPL:  taken_out = ~n;
      `SABX_OP_BMS:  taken_out = i;
      `SABX_OP_BMC:  taken_out = ~i;
      `SABX_OP_BRANCH_HALF_CARRY_SET: taken_out = h;
      `SABX_OP_BRANCH_HALF_CARRY_CLEAR: taken_out = ~h;
      `SABX_OP_BIH:  taken_out = irq_level_in;
      `SABX_OP_BIL:  taken_out = ~irq_level_in;
      `SABX_OP_BRA:  taken_out = 1'b1;
      `SABX_OP_BRN:  taken_out = 1'b0;
      default:       is_branch_out = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

// [verilog/sabx_consts.svh]
// constants for the signed-adjust and branch execution block
// assumes inclusion by bare name from the package and the modules
`ifndef SABX_CONSTS_SVH
`define SABX_CONSTS_SVH

// register byte offsets on the avalon slave
`define SABX_REG_CTRL    5'h00
`define SABX_REG_STATUS  5'h04
`define SABX_REG_SP      5'h08
`define SABX_REG_HX      5'h0c
`define SABX_REG_PC      5'h10
`define SABX_REG_FLAGS   5'h14
`define SABX_REG_LASTOP  5'h18

// field positions
`define SABX_CTRL_RUN    0
`define SABX_CTRL_STEP   1
`define SABX_STAT_BUSY   0
`define SABX_STAT_TAKEN  1
`define SABX_STAT_ILL    2
`define SABX_STAT_CYC    8
`define SABX_FLAG_V      7
`define SABX_FLAG_H      4
`define SABX_FLAG_I      3
`define SABX_FLAG_N      2
`define SABX_FLAG_Z      1
`define SABX_FLAG_C      0

// reset values and the flag bits forced to one
`define SABX_RST_SP      16'h00ff
`define SABX_RST_HX      16'h0000
`define SABX_RST_PC      16'h0000
`define SABX_RST_FLAGS   8'h68
`define SABX_FLAGS_ONES  8'h60

// opcodes
`define SABX_OP_STACK_ADJ  8'ha7
`define SABX_OP_INDEX_ADJ  8'haf
`define SABX_OP_LOW_DEC    8'h5a
`define SABX_OP_BRA        8'h20
`define SABX_OP_BRN        8'h21
`define SABX_OP_BHI        8'h22
`define SABX_OP_BLS        8'h23
`define SABX_OP_BCC        8'h24
`define SABX_OP_BCS        8'h25
`define SABX_OP_BNE        8'h26
`define SABX_OP_BEQ        8'h27
`define SABX_OP_BRANCH_HALF_CARRY_CLEAR       8'h28
`define SABX_OP_BRANCH_HALF_CARRY_SET       8'h29
`define SABX_OP_BPL        8'h2a
`define SABX_OP_BMI        8'h2b
`define SABX_OP_BMC        8'h2c
`define SABX_OP_BMS        8'h2d
`define SABX_OP_BIL        8'h2e
`define SABX_OP_BIH        8'h2f
`define SABX_OP_BGE        8'h90
`define SABX_OP_BLT        8'h91
`define SABX_OP_BGT        8'h92
`define SABX_OP_BLE        8'h93

// cycle counts per instruction
`define SABX_CYC_DEC     4'h1
`define SABX_CYC_ADJ     4'h2
`define SABX_CYC_BR      4'h3

`endif

// [verilog/sabx_exec.sv]
// execution block for stack/index adjust, low index decrement and branches
// assumes program memory answers reads combinationally on the same clock
// and an avalon-mm master that holds each request until waitrequest is low
`timescale 1ns/100ps
`default_nettype none
`include "sabx_consts.svh"
module sabx_exec
  import sabx_pkg::*;
#(
  parameter logic [7:0] LOW_DEC_OPCODE = `SABX_OP_LOW_DEC
)
(
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic [4:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic [31:0]      avs_readdata_out,
  output logic             avs_waitrequest_out,
  output logic [15:0]      mem_addr_out,
  output logic             mem_rd_out,
  input  wire logic [7:0]  mem_rdata_in,
  input  wire logic        irq_pin_in
);
  sabx_state_t state_q;
  sabx_state_t state_d;
  sabx_word_t  sp_q;
  sabx_word_t  hx_q;
  sabx_word_t  pc_q;
  sabx_byte_t  flags_q;
  sabx_byte_t  op_q;
  sabx_byte_t  opnd_q;
  logic        run_q;
  logic        step_q;
  logic        taken_q;
  logic        illegal_q;
  logic [3:0]  cyc_q;
  logic [3:0]  last_cyc_q;
  logic        ack_q;
  logic [31:0] rdata_q;
  logic        irq_meta_q;
  logic        irq_sync_q;

  function automatic logic [15:0] be_merge(input logic [15:0] old_v,
                                           input logic [15:0] new_v,
                                           input logic [1:0]  be);
    be_merge = {be[1] ? new_v[15:8] : old_v[15:8], be[0] ? new_v[7:0] : old_v[7:0]};
  endfunction

  // avalon decode: one wait state, so read data come from a register
  wire bus_req  = avs_read_in | avs_write_in;
  wire bus_take = bus_req & ~ack_q;
  wire wr_fire  = avs_write_in & ack_q;
  wire hit_ctrl = avs_address_in == `SABX_REG_CTRL;
  wire hit_stat = avs_address_in == `SABX_REG_STATUS;
  wire hit_sp   = avs_address_in == `SABX_REG_SP;
  wire hit_hx   = avs_address_in == `SABX_REG_HX;
  wire hit_pc   = avs_address_in == `SABX_REG_PC;
  wire hit_flg  = avs_address_in == `SABX_REG_FLAGS;
  wire hit_lop  = avs_address_in == `SABX_REG_LASTOP;
  wire idle     = state_q == ST_IDLE;
  // architectural registers only change from the bus between instructions
  wire wr_ctrl  = wr_fire & hit_ctrl & avs_byteenable_in[0];
  wire wr_stat  = wr_fire & hit_stat & avs_byteenable_in[0];
  wire wr_sp    = wr_fire & hit_sp & idle;
  wire wr_hx    = wr_fire & hit_hx & idle;
  wire wr_pc    = wr_fire & hit_pc & idle;
  wire wr_flg   = wr_fire & hit_flg & idle & avs_byteenable_in[0];
  wire [1:0] be_lo = avs_byteenable_in[1:0];

  wire [31:0] status_word = {20'h00000, last_cyc_q, 5'h00, illegal_q, taken_q, ~idle};
  wire [31:0] rd_mux =
    hit_ctrl ? {30'h0, step_q, run_q} :
    hit_stat ? status_word :
    hit_sp   ? {16'h0000, sp_q} :
    hit_hx   ? {16'h0000, hx_q} :
    hit_pc   ? {16'h0000, pc_q} :
    hit_flg  ? {24'h000000, flags_q} :
    hit_lop  ? {24'h000000, op_q} : 32'h00000000;

  // decode: the opcode is live from memory during the first cycle
  wire sabx_byte_t op_now = (state_q == ST_OP) ? mem_rdata_in : op_q;
  logic is_branch;
  logic br_taken;
  wire is_stack_adj = op_now == `SABX_OP_STACK_ADJ;
  wire is_index_adj = op_now == `SABX_OP_INDEX_ADJ;
  wire is_low_dec   = op_now == LOW_DEC_OPCODE;
  wire legal        = is_stack_adj | is_index_adj | is_low_dec | is_branch;
  wire start        = idle & (run_q | step_q);

  sabx_cond u_cond (
    .opcode_in     (op_now),
    .flags_in      (flags_q),
    .irq_level_in  (irq_sync_q),
    .is_branch_out (is_branch),
    .taken_out     (br_taken)
  );

  // one shared adder: adjust base in the operand cycle, pc in the branch cycle
  wire sabx_word_t adj_base = (op_q == `SABX_OP_STACK_ADJ) ? sp_q : hx_q;
  wire sabx_word_t add_base = (state_q == ST_BR) ? pc_q : adj_base;
  wire sabx_byte_t add_off  = (state_q == ST_BR) ? opnd_q : mem_rdata_in;
  logic [15:0] add_sum;

  sabx_adder u_adder (
    .base_in   (add_base),
    .offset_in (add_off),
    .sum_out   (add_sum)
  );

  wire op_cyc   = state_q == ST_OP;
  wire opnd_cyc = state_q == ST_OPND;
  wire do_sadj  = opnd_cyc & (op_q == `SABX_OP_STACK_ADJ);
  wire do_xadj  = opnd_cyc & (op_q == `SABX_OP_INDEX_ADJ);
  wire do_dec   = op_cyc & is_low_dec;
  wire finish   = (op_cyc & (is_low_dec | ~legal)) | do_sadj | do_xadj | (state_q == ST_BR);
  wire [7:0] dec_x = hx_q[7:0] - 8'h01;
  wire dec_v = hx_q[7:0] == 8'h80;
  wire dec_z = dec_x == 8'h00;
  wire [7:0] dec_flags = {dec_v, 2'b11, flags_q[`SABX_FLAG_H], flags_q[`SABX_FLAG_I],
                          dec_x[7], dec_z, flags_q[`SABX_FLAG_C]};

  wire sabx_word_t sp_d = wr_sp ? be_merge(sp_q, avs_writedata_in[15:0], be_lo) :
                          do_sadj ? add_sum : sp_q;
  // the decrement keeps the carry inside the low byte
  wire sabx_word_t hx_d = wr_hx ? be_merge(hx_q, avs_writedata_in[15:0], be_lo) :
                          do_dec ? {hx_q[15:8], dec_x} :
                          do_xadj ? add_sum : hx_q;
  wire sabx_word_t pc_d = wr_pc ? be_merge(pc_q, avs_writedata_in[15:0], be_lo) :
                          (op_cyc | opnd_cyc) ? pc_q + 16'h0001 :
                          ((state_q == ST_BR) & br_taken) ? add_sum : pc_q;
  // adjusts and branches leave the flags alone
  wire sabx_byte_t flags_d = wr_flg ? (avs_writedata_in[7:0] | `SABX_FLAGS_ONES) :
                             do_dec ? dec_flags : flags_q;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: if (start) begin
        state_d = ST_OP;
      end
      ST_OP: begin
        if (legal & ~is_low_dec) begin
          state_d = ST_OPND;
        end else begin
          state_d = ST_IDLE;
        end
      end
      ST_OPND: begin
        if (do_sadj | do_xadj) begin
          state_d = ST_IDLE;
        end else begin
          state_d = ST_BR;
        end
      end
      ST_BR: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q <= ST_IDLE;
      sp_q    <= `SABX_RST_SP;
      hx_q    <= `SABX_RST_HX;
      pc_q    <= `SABX_RST_PC;
      flags_q <= `SABX_RST_FLAGS;
    end else begin
      state_q <= state_d;
      sp_q    <= sp_d;
      hx_q    <= hx_d;
      pc_q    <= pc_d;
      flags_q <= flags_d;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      op_q   <= 8'h00;
      opnd_q <= 8'h00;
    end else begin
      op_q   <= op_cyc ? mem_rdata_in : op_q;
      opnd_q <= opnd_cyc ? mem_rdata_in : opnd_q;
    end
  end

  // instruction cycle counter, latched when an instruction ends
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cyc_q      <= 4'h0;
      last_cyc_q <= 4'h0;
      taken_q    <= 1'b0;
    end else begin
      cyc_q      <= idle ? 4'h0 : cyc_q + 4'h1;
      last_cyc_q <= finish ? cyc_q + 4'h1 : last_cyc_q;
      taken_q    <= finish ? ((state_q == ST_BR) & br_taken) : taken_q;
    end
  end

  // hardware sets win over software clears in the same cycle
  wire illegal_set = op_cyc & ~legal;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      run_q     <= 1'b0;
      step_q    <= 1'b0;
      illegal_q <= 1'b0;
    end else begin
      // an illegal opcode stops the run even if software sets run in the same cycle
      run_q     <= (wr_ctrl ? avs_writedata_in[`SABX_CTRL_RUN] : run_q) & ~illegal_set;
      step_q    <= (wr_ctrl & avs_writedata_in[`SABX_CTRL_STEP]) | (step_q & ~start);
      illegal_q <= illegal_set | (illegal_q & ~(wr_stat & avs_writedata_in[`SABX_STAT_ILL]));
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h00000000;
    end else begin
      ack_q   <= bus_take;
      rdata_q <= (bus_take & avs_read_in) ? rd_mux : rdata_q;
    end
  end

  // the pin is asynchronous; only the second stage is used
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_meta_q <= 1'b0;
      irq_sync_q <= 1'b0;
    end else begin
      irq_meta_q <= irq_pin_in;
      irq_sync_q <= irq_meta_q;
    end
  end

  assign avs_readdata_out    = rdata_q;
  assign avs_waitrequest_out = bus_req & ~ack_q;
  assign mem_addr_out        = pc_q;
  assign mem_rd_out          = op_cyc | opnd_cyc;

  property p_stack_sum;
    @(posedge clk_in) disable iff (!rst_n_in)
      do_sadj |=> sp_q == $past(sp_q) + {{8{$past(mem_rdata_in[7])}}, $past(mem_rdata_in)};
  endproperty
  a_stack_sum: assert property (p_stack_sum)
    else $error("stack adjust sum wrong");

  property p_stack_cycles;
    @(posedge clk_in) disable iff (!rst_n_in)
      (op_cyc && mem_rdata_in == `SABX_OP_STACK_ADJ) |=> opnd_cyc ##1
        (idle && last_cyc_q == `SABX_CYC_ADJ);
  endproperty
  a_stack_cycles: assert property (p_stack_cycles)
    else $error("stack adjust did not finish in two cycles");

  property p_index_sum;
    @(posedge clk_in) disable iff (!rst_n_in)
      do_xadj |=> hx_q == $past(hx_q) + {{8{$past(mem_rdata_in[7])}}, $past(mem_rdata_in)};
  endproperty
  a_index_sum: assert property (p_index_sum)
    else $error("index adjust sum wrong");

  property p_index_cycles;
    @(posedge clk_in) disable iff (!rst_n_in)
      (op_cyc && mem_rdata_in == `SABX_OP_INDEX_ADJ) |=> opnd_cyc ##1
        (idle && last_cyc_q == `SABX_CYC_ADJ);
  endproperty
  a_index_cycles: assert property (p_index_cycles)
    else $error("index adjust did not finish in two cycles");

  property p_dec_no_carry;
    @(posedge clk_in) disable iff (!rst_n_in)
      do_dec |=> hx_q[15:8] == $past(hx_q[15:8]) && hx_q[7:0] == $past(hx_q[7:0]) - 8'h01;
  endproperty
  a_dec_no_carry: assert property (p_dec_no_carry)
    else $error("low decrement touched the high byte");

  property p_adj_flags;
    @(posedge clk_in) disable iff (!rst_n_in)
      (do_sadj || do_xadj) |=> $stable(flags_q);
  endproperty
  a_adj_flags: assert property (p_adj_flags)
    else $error("adjust changed the flags");

  property p_neg_imm;
    @(posedge clk_in) disable iff (!rst_n_in)
      (do_xadj && mem_rdata_in == 8'h80) |=> hx_q == $past(hx_q) - 16'h0080;
  endproperty
  a_neg_imm: assert property (p_neg_imm)
    else $error("immediate 80 did not subtract 128");

  property p_bge;
    @(posedge clk_in) disable iff (!rst_n_in)
      (state_q == ST_BR && op_q == `SABX_OP_BGE && !(flags_q[7] ^ flags_q[2])) |=>
        pc_q == $past(pc_q) + {{8{$past(opnd_q[7])}}, $past(opnd_q)} && last_cyc_q == 4'h3;
  endproperty
  a_bge: assert property (p_bge)
    else $error("signed ge branch target or timing wrong");

  property p_branch_flags;
    @(posedge clk_in) disable iff (!rst_n_in)
      (state_q == ST_BR) |=> ($stable(flags_q) && idle);
  endproperty
  a_branch_flags: assert property (p_branch_flags)
    else $error("branch changed flags");

  property p_never;
    @(posedge clk_in) disable iff (!rst_n_in)
      (op_cyc && mem_rdata_in == `SABX_OP_BRN) |=> ##1 pc_q == $past(pc_q, 2) + 16'h0002 ##1
        (pc_q == $past(pc_q) && !taken_q);
  endproperty
  a_never: assert property (p_never)
    else $error("never branch moved the pc or skipped its operand");

  property p_fetch_step;
    @(posedge clk_in) disable iff (!rst_n_in)
      (op_cyc || opnd_cyc) |=> pc_q == $past(pc_q) + 16'h0001;
  endproperty
  a_fetch_step: assert property (p_fetch_step)
    else $error("fetch did not step the pc by one");

  property p_taken_target;
    @(posedge clk_in) disable iff (!rst_n_in)
      (state_q == ST_BR && br_taken) |=>
        pc_q == $past(pc_q) + {{8{$past(opnd_q[7])}}, $past(opnd_q)} && taken_q;
  endproperty
  a_taken_target: assert property (p_taken_target)
    else $error("taken branch target wrong");

  property p_not_taken;
    @(posedge clk_in) disable iff (!rst_n_in)
      (state_q == ST_BR && !br_taken) |=> pc_q == $past(pc_q) && !taken_q;
  endproperty
  a_not_taken: assert property (p_not_taken)
    else $error("untaken branch moved the pc");

  property p_irq_level;
    @(posedge clk_in) disable iff (!rst_n_in)
      (state_q == ST_BR && op_q == `SABX_OP_BIH) |=> taken_q == $past(irq_sync_q);
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("pin branch did not follow the pin level");
endmodule
`default_nettype wire

// [verilog/sabx_pkg.sv]
// types shared by the execution block
// assumes the constants header is on the include path
`default_nettype none
`include "sabx_consts.svh"
package sabx_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_OP, ST_OPND, ST_BR} sabx_state_t;
  typedef logic [15:0] sabx_word_t;
  typedef logic [7:0]  sabx_byte_t;
endpackage
`default_nettype wire
